// ### rtl/rcs_pkg.sv
// Constants, states and carriers of the reset configuration sequencer
package rcs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int MR_PULSE_NS = 20;
  localparam int MR_PULSE_CYC = (MR_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int STRAP_HOLD_NS = 10;
  localparam int STRAP_HOLD_CYC = (STRAP_HOLD_NS * CLK_MHZ / 1000 > 0) ?
                                  STRAP_HOLD_NS * CLK_MHZ / 1000 : 1;
  localparam int HOST_WAIT_NOLOAD_MS = 15;
  localparam int HOST_WAIT_NODEV_MS = 150;

  // ----------------------------------------------------------------
  // Straps and EEPROM search
  // ----------------------------------------------------------------
  localparam int GPIO_W = 8;
  localparam int CFG_W = 4;
  localparam int SYNC_W = GPIO_W + 2;
  localparam int STRAP_CFG_LSB = 0;
  localparam int STRAP_SPI_BIT = 4;
  localparam int STRAP_EE_BIT = 5;
  localparam logic [6:0] EE_ADDR_FIRST = 7'h50;
  localparam logic [6:0] EE_ADDR_LAST = 7'h57;
  localparam logic [1:0] SPD_1MHZ = 2'h0;
  localparam logic [1:0] SPD_100KHZ = 2'h2;
  localparam logic [15:0] EE_OFF_LOW = 16'h0000;
  localparam logic [15:0] EE_OFF_HIGH = 16'hf000;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int AXI_ADDR_W = 8;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] REG_FUNC_EN = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] REG_STRAP = 8'h08;
  localparam logic [GPIO_W-1:0] FUNC_EN_RST = 8'h00;
  localparam int ST_DONE = 0;
  localparam int ST_OTP_OK = 1;
  localparam int ST_OTP_ERR = 2;
  localparam int ST_NO_EE = 3;
  localparam int ST_EE_OK = 4;
  localparam int ST_EE_ERR = 5;
  localparam int ST_DEFAULTS = 6;
  localparam int ST_HOTFIX = 7;
  localparam int ST_UPDATED = 8;
  localparam int ST_SPI = 9;
  localparam int ST_CFG_LSB = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SQ_INFO = 4'h0, SQ_PLLCAL = 4'h1, SQ_WAITREL = 4'h3, SQ_DEFAULTS = 4'h2,
    SQ_PROBE = 4'h6, SQ_UPDATE = 4'h7, SQ_OTPCFG = 4'h5, SQ_EECFG = 4'h4,
    SQ_HOTFIX = 4'hc, SQ_PLLRECAL = 4'hd, SQ_SERIAL = 4'hf, SQ_APPLY = 4'he,
    SQ_MONITOR = 4'ha, SQ_ALARM = 4'hb, SQ_RUN = 4'h9
  } rcs_state_e;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_INFO = 4'h1, CMD_PLL_CAL = 4'h2, CMD_DEFAULTS = 4'h3,
    CMD_PROBE = 4'h4, CMD_UPDATE = 4'h5, CMD_OTP_CFG = 4'h6, CMD_EE_CFG = 4'h7,
    CMD_HOTFIX = 4'h8, CMD_APPLY = 4'h9
  } rcs_cmd_e;

  typedef struct packed {
    rcs_cmd_e cmd;
    logic [6:0] devAddr;
    logic [1:0] speed;
    logic [15:0] offset;
    logic [CFG_W-1:0] cfgNum;
  } rcs_job_s;

  typedef struct packed {
    logic done;
    logic ok;
    logic fbDivProg;
    logic protoSpi;
  } rcs_rsp_s;

endpackage : rcs_pkg

// ### rtl/rcs_reset_config_sequencer.sv
// Reset configuration sequencer with AXI4-Lite status and control registers
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/100ps

module rcs_reset_config_sequencer import rcs_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic masterResetN,
  input wire logic testModeN,
  input wire logic [GPIO_W-1:0] gpioIn,
  input wire rcs_rsp_s jobRsp,
  output logic jobReq,
  output rcs_job_s job,
  output logic clkOutEn,
  output logic gpioDrive,
  output logic serialEn,
  output logic serialSpi,
  output logic spi4Wire,
  output logic pllCalParallel,
  output logic monEn,
  output logic alarmEn,
  output logic [GPIO_W-1:0] funcPwrEn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef struct packed {
    rcs_state_e st;
    logic reqOn;
    rcs_job_s job;
    logic [GPIO_W-1:0] strap;
    logic mrPrev;
    logic [6:0] addr;
    logic [1:0] speed;
    logic offHigh;
    logic eePresent;
    logic updDone;
    logic otpOk;
    logic otpErr;
    logic noEe;
    logic eeOk;
    logic eeErr;
    logic hotfix;
    logic pllPar;
    logic serEn;
    logic serSpi;
    logic spi4;
    logic clkEn;
    logic gpioDrv;
    logic monOn;
    logic almOn;
    logic [GPIO_W-1:0] funcPwr;
  } rcs_seq_s;

  typedef struct packed {
    logic awHave;
    logic [AXI_ADDR_W-1:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awReady;
    logic wReady;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [GPIO_W-1:0] funcEn;
  } rcs_bus_s;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Straps ride the same two stages as the reset pin, so the strap word
  // and the reset edge stay aligned to the cycle.
  logic [SYNC_W-1:0] pinRaw;
  logic [SYNC_W-1:0] pinMeta_q;
  logic [SYNC_W-1:0] pinSync_q;
  logic mrN;
  logic testN;
  logic [GPIO_W-1:0] gpioS;

  assign pinRaw = {testModeN, masterResetN, gpioIn};

  generate
    for (genvar i = 0; i < SYNC_W; i++) begin : gSync
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          pinMeta_q[i] <= 1'h0;
          pinSync_q[i] <= 1'h0;
        end else begin
          pinMeta_q[i] <= pinRaw[i];
          pinSync_q[i] <= pinMeta_q[i];
        end
      end
    end
  endgenerate

  assign gpioS = pinSync_q[GPIO_W-1:0];
  assign mrN = pinSync_q[GPIO_W];
  assign testN = pinSync_q[GPIO_W+1];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  rcs_seq_s seq_q;
  rcs_seq_s seq_d;
  rcs_bus_s bus_q;
  rcs_bus_s bus_d;
  logic dn;

  function automatic rcs_cmd_e cmdOf(input rcs_state_e st);
    case (st)
      SQ_INFO: cmdOf = CMD_INFO;
      SQ_PLLCAL: cmdOf = CMD_PLL_CAL;
      SQ_DEFAULTS: cmdOf = CMD_DEFAULTS;
      SQ_PROBE: cmdOf = CMD_PROBE;
      SQ_UPDATE: cmdOf = CMD_UPDATE;
      SQ_OTPCFG: cmdOf = CMD_OTP_CFG;
      SQ_EECFG: cmdOf = CMD_EE_CFG;
      SQ_HOTFIX: cmdOf = CMD_HOTFIX;
      SQ_PLLRECAL: cmdOf = CMD_PLL_CAL;
      SQ_APPLY: cmdOf = CMD_APPLY;
      default: cmdOf = CMD_NONE;
    endcase
  endfunction : cmdOf

  assign dn = seq_q.reqOn && jobRsp.done;

  always_comb begin : seqNext
    seq_d = seq_q;
    seq_d.mrPrev = mrN;
    if (!seq_q.mrPrev && mrN) begin
      seq_d.strap = gpioS;
    end
    case (seq_q.st)
      SQ_INFO: if (dn) seq_d.st = SQ_PLLCAL;
      SQ_PLLCAL: if (dn) seq_d.st = SQ_WAITREL;
      SQ_WAITREL: if (mrN && testN) begin
        seq_d.st = SQ_DEFAULTS;
        {seq_d.otpOk, seq_d.otpErr, seq_d.noEe, seq_d.eeOk, seq_d.eeErr} = '0;
        {seq_d.hotfix, seq_d.pllPar, seq_d.eePresent} = '0;
      end
      SQ_DEFAULTS: begin
        seq_d.serSpi = seq_q.strap[STRAP_SPI_BIT];
        seq_d.spi4 = 1'h1;
        seq_d.addr = EE_ADDR_FIRST;
        seq_d.speed = SPD_1MHZ;
        seq_d.offHigh = 1'h0;
        if (dn) seq_d.st = seq_q.strap[STRAP_EE_BIT] ? SQ_PROBE : SQ_OTPCFG;
      end
      SQ_PROBE: if (dn) begin
        if (jobRsp.ok) begin
          seq_d.eePresent = 1'h1;
          seq_d.st = seq_q.updDone ? SQ_OTPCFG : SQ_UPDATE;
        end else if (seq_q.addr != EE_ADDR_LAST) begin
          seq_d.addr = seq_q.addr + 7'h01;
        end else begin
          seq_d.addr = EE_ADDR_FIRST;
          if (seq_q.speed == SPD_100KHZ) begin
            seq_d.noEe = 1'h1;
            seq_d.st = SQ_OTPCFG;
          end else begin
            seq_d.speed = seq_q.speed + 2'h1;
          end
        end
      end
      SQ_UPDATE: if (dn) begin
        if (jobRsp.ok) begin
          // Remembered across the restart so an applied update is not re-run forever
          seq_d.updDone = 1'h1;
          seq_d.st = SQ_INFO;
        end else if (seq_q.addr == EE_ADDR_LAST) begin
          seq_d.st = SQ_OTPCFG;
        end else begin
          seq_d.addr = seq_q.addr + 7'h01;
        end
      end
      SQ_OTPCFG: if (dn) begin
        seq_d.addr = EE_ADDR_FIRST;
        seq_d.offHigh = 1'h0;
        seq_d.st = seq_q.eePresent ? SQ_EECFG : SQ_HOTFIX;
        if (jobRsp.ok) begin
          seq_d.otpOk = 1'h1;
          seq_d.pllPar = jobRsp.fbDivProg;
          seq_d.serSpi = jobRsp.protoSpi;
        end else begin
          seq_d.otpErr = 1'h1;
        end
      end
      SQ_EECFG: if (dn) begin
        if (jobRsp.ok) begin
          seq_d.eeOk = 1'h1;
          seq_d.serSpi = jobRsp.protoSpi;
          seq_d.st = SQ_HOTFIX;
        end else if (!seq_q.offHigh) begin
          seq_d.offHigh = 1'h1;
        end else if (seq_q.addr == EE_ADDR_LAST) begin
          seq_d.eeErr = 1'h1;
          seq_d.st = SQ_HOTFIX;
        end else begin
          seq_d.offHigh = 1'h0;
          seq_d.addr = seq_q.addr + 7'h01;
        end
      end
      SQ_HOTFIX: if (dn) begin
        seq_d.hotfix = jobRsp.ok;
        seq_d.st = SQ_PLLRECAL;
      end
      SQ_PLLRECAL: begin
        if (!(seq_q.otpOk || seq_q.eeOk) || dn) begin
          seq_d.pllPar = 1'h0;
          seq_d.st = SQ_SERIAL;
        end
      end
      SQ_SERIAL: begin
        seq_d.serEn = 1'h1;
        seq_d.st = SQ_APPLY;
      end
      SQ_APPLY: if (dn) begin
        seq_d.clkEn = 1'h1;
        seq_d.gpioDrv = 1'h1;
        seq_d.st = SQ_MONITOR;
      end
      SQ_MONITOR: begin
        seq_d.monOn = 1'h1;
        seq_d.st = SQ_ALARM;
      end
      SQ_ALARM: begin
        seq_d.almOn = 1'h1;
        seq_d.st = SQ_RUN;
      end
      SQ_RUN: seq_d.funcPwr = bus_q.funcEn;
      default: seq_d.st = SQ_INFO;
    endcase
    if (!mrN) begin
      {seq_d.clkEn, seq_d.gpioDrv, seq_d.serEn, seq_d.monOn, seq_d.almOn} = '0;
      seq_d.funcPwr = FUNC_EN_RST;
      if (seq_q.st != SQ_INFO && seq_q.st != SQ_PLLCAL && seq_q.st != SQ_WAITREL) begin
        seq_d.st = SQ_INFO;
      end
    end
    // A request drops for a cycle between jobs so each command is seen fresh
    seq_d.reqOn = (cmdOf(seq_d.st) != CMD_NONE) && (seq_d.st == seq_q.st) && !dn;
    seq_d.job.cmd = cmdOf(seq_d.st);
    seq_d.job.devAddr = seq_d.addr;
    seq_d.job.speed = seq_d.speed;
    seq_d.job.offset = seq_d.offHigh ? EE_OFF_HIGH : EE_OFF_LOW;
    seq_d.job.cfgNum = seq_d.strap[STRAP_CFG_LSB +: CFG_W];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      seq_q <= '0;
      seq_q.st <= SQ_INFO;
      seq_q.job.cmd <= CMD_NONE;
    end else begin
      seq_q <= seq_d;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic [31:0] statusWord;

  always_comb begin : statusBuild
    statusWord = '0;
    statusWord[ST_DONE] = seq_q.st == SQ_RUN;
    statusWord[ST_OTP_OK] = seq_q.otpOk;
    statusWord[ST_OTP_ERR] = seq_q.otpErr;
    statusWord[ST_NO_EE] = seq_q.noEe;
    statusWord[ST_EE_OK] = seq_q.eeOk;
    statusWord[ST_EE_ERR] = seq_q.eeErr;
    statusWord[ST_DEFAULTS] = (seq_q.st == SQ_RUN) && !seq_q.otpOk && !seq_q.eeOk;
    statusWord[ST_HOTFIX] = seq_q.hotfix;
    statusWord[ST_UPDATED] = seq_q.updDone;
    statusWord[ST_SPI] = seq_q.serSpi;
    statusWord[ST_CFG_LSB +: CFG_W] = seq_q.otpOk ? seq_q.job.cfgNum : '0;
  end

  always_comb begin : busNext
    bus_d = bus_q;
    if (s_axi_awvalid && bus_q.awReady) begin
      bus_d.awHave = 1'h1;
      bus_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && bus_q.wReady) begin
      bus_d.wHave = 1'h1;
      bus_d.wData = s_axi_wdata;
      bus_d.wStrb = s_axi_wstrb;
    end
    if (bus_q.bValid && s_axi_bready) bus_d.bValid = 1'h0;
    if (bus_q.awHave && bus_q.wHave) begin
      bus_d.awHave = 1'h0;
      bus_d.wHave = 1'h0;
      bus_d.bValid = 1'h1;
      bus_d.bResp = RESP_OKAY;
      if (!seq_q.serEn) begin
        bus_d.bResp = RESP_SLVERR;
      end else if (bus_q.awAddr == REG_FUNC_EN) begin
        if (bus_q.wStrb[0]) bus_d.funcEn = bus_q.wData[GPIO_W-1:0];
      end else if (bus_q.awAddr != REG_STATUS && bus_q.awAddr != REG_STRAP) begin
        bus_d.bResp = RESP_DECERR;
      end
    end
    if (bus_q.rValid && s_axi_rready) bus_d.rValid = 1'h0;
    if (s_axi_arvalid && bus_q.arReady) begin
      bus_d.rValid = 1'h1;
      bus_d.rData = '0;
      bus_d.rResp = RESP_OKAY;
      if (!seq_q.serEn) begin
        bus_d.rResp = RESP_SLVERR;
      end else begin
        case (s_axi_araddr)
          REG_STATUS: bus_d.rData = statusWord;
          REG_FUNC_EN: bus_d.rData[GPIO_W-1:0] = bus_q.funcEn;
          REG_STRAP: bus_d.rData[GPIO_W-1:0] = seq_q.strap;
          default: bus_d.rResp = RESP_DECERR;
        endcase
      end
    end
    bus_d.awReady = !bus_d.awHave && !bus_d.bValid;
    bus_d.wReady = !bus_d.wHave && !bus_d.bValid;
    bus_d.arReady = !bus_d.rValid;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bus_q <= '0;
      bus_q.funcEn <= FUNC_EN_RST;
    end else begin
      bus_q <= bus_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign jobReq = seq_q.reqOn;
  assign job = seq_q.job;
  assign clkOutEn = seq_q.clkEn;
  assign gpioDrive = seq_q.gpioDrv;
  assign serialEn = seq_q.serEn;
  assign serialSpi = seq_q.serSpi;
  assign spi4Wire = seq_q.spi4;
  assign pllCalParallel = seq_q.pllPar;
  assign monEn = seq_q.monOn;
  assign alarmEn = seq_q.almOn;
  assign funcPwrEn = seq_q.funcPwr;
  assign s_axi_awready = bus_q.awReady;
  assign s_axi_wready = bus_q.wReady;
  assign s_axi_bvalid = bus_q.bValid;
  assign s_axi_bresp = bus_q.bResp;
  assign s_axi_arready = bus_q.arReady;
  assign s_axi_rvalid = bus_q.rValid;
  assign s_axi_rdata = bus_q.rData;
  assign s_axi_rresp = bus_q.rResp;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_reset_quiet: assert property (
    !mrN |=> !clkOutEn && !gpioDrive && !serialEn && !monEn && funcPwrEn == '0)
    else $error("Outputs active while master reset held");
  a_start_rise: assert property (
    seq_q.st == SQ_WAITREL && mrN && testN |=> seq_q.st == SQ_DEFAULTS)
    else $error("Sequence did not start on reset release");
  a_test_hold: assert property (
    seq_q.st == SQ_WAITREL && !testN |=> seq_q.st == SQ_WAITREL)
    else $error("Sequence started with test mode low");
  a_strap_latch: assert property (
    $rose(mrN) |=> seq_q.strap == $past(gpioS))
    else $error("Straps not latched at reset rise");
  a_default_pins: assert property (
    seq_q.st == SQ_DEFAULTS |=> !clkOutEn && !gpioDrive)
    else $error("Default image step changed pins");
  a_spi_strap: assert property (
    seq_q.st == SQ_DEFAULTS |=> serialSpi == seq_q.strap[STRAP_SPI_BIT] && spi4Wire)
    else $error("Protocol not taken from strap");
  a_otp_fail: assert property (
    seq_q.st == SQ_OTPCFG && dn && !jobRsp.ok && mrN |=> seq_q.otpErr && !seq_q.otpOk)
    else $error("OTP failure not reported");
  a_update_restart: assert property (
    seq_q.st == SQ_UPDATE && dn && jobRsp.ok && mrN |=> seq_q.st == SQ_INFO)
    else $error("Update did not restart sequence");
  a_probe_speed: assert property (
    seq_q.st == SQ_PROBE && dn && !jobRsp.ok && seq_q.addr == EE_ADDR_LAST &&
    seq_q.speed != SPD_100KHZ && mrN
    |=> seq_q.addr == EE_ADDR_FIRST && seq_q.speed == $past(seq_q.speed) + 2'h1)
    else $error("Probe did not advance to next speed");
  a_finish_order: assert property (
    seq_q.st == SQ_SERIAL && mrN |=> serialEn && !clkOutEn ##1 !monEn)
    else $error("Completion order broken");
  a_port_mute: assert property (
    s_axi_arvalid && s_axi_arready && !serialEn |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR)
    else $error("Read served before ports enabled");

endmodule : rcs_reset_config_sequencer

// ### bench/rcs_job_partner.sv
// Job engine model: OTP and serial EEPROM behind the sequencer
`timescale 1ns/100ps
module rcs_job_partner import rcs_pkg::*; (
  input wire logic clk_sys,
  input wire logic jobReq,
  input wire rcs_job_s job,
  input wire logic [6:0] eeAddr,
  input wire logic [6:0] cfgAddr,
  input wire logic [1:0] eeSpd,
  input wire logic eeOn,
  input wire logic updOn,
  input wire logic otpOk,
  input wire logic spi,
  output rcs_rsp_s jobRsp
);
  logic ok;
  logic tog_q = 1'h0;
  logic [2:0] wait_q = 3'h0;
  initial jobRsp = '0;
  always_comb begin
    case (job.cmd)
      CMD_PROBE: ok = eeOn && job.devAddr == eeAddr && job.speed == eeSpd;
      CMD_UPDATE: ok = updOn && job.devAddr == eeAddr;
      CMD_OTP_CFG: ok = otpOk;
      CMD_EE_CFG: ok = eeOn && job.devAddr == cfgAddr && job.offset == EE_OFF_HIGH;
      default: ok = 1'h1;
    endcase
  end
  // Odd addresses answer slowly, so both fast and slow answers occur
  always @(posedge clk_sys) begin
    tog_q <= !tog_q;
    wait_q <= (jobReq && !jobRsp.done) ? wait_q + 3'h1 : 3'h0;
    if (jobReq && !jobRsp.done && wait_q == {job.devAddr[0], 2'h0}) begin
      jobRsp <= '{1'h1, ok, otpOk, spi};
    end else begin
      // Qualifiers mean nothing outside done, so they keep moving
      jobRsp <= '{1'h0, tog_q, tog_q, !tog_q};
    end
  end
endmodule : rcs_job_partner

// ### bench/tb_top.sv
// Self-checking bench of the reset configuration sequencer
`timescale 1ns/100ps
module tb_top;
  import rcs_pkg::*;
  logic clk_sys, rst_n, masterResetN, testModeN, jobReq, clkOutEn, gpioDrive, serialEn;
  logic serialSpi, spi4Wire, pllCalParallel, monEn, alarmEn, eeOn, updOn, otpOk, spi;
  logic [GPIO_W-1:0] gpioIn, funcPwrEn, strap_q;
  logic [6:0] eeAddr, cfgAddr;
  logic [1:0] eeSpd, s_axi_bresp, s_axi_rresp;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  rcs_rsp_s jobRsp;
  rcs_job_s job;
  rcs_job_s jobLog[$];
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;

  rcs_reset_config_sequencer u_rcs_reset_config_sequencer (
    .clk_sys, .rst_n, .masterResetN, .testModeN, .gpioIn, .jobRsp, .jobReq, .job, .clkOutEn,
    .gpioDrive, .serialEn, .serialSpi, .spi4Wire, .pllCalParallel, .monEn, .alarmEn, .funcPwrEn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  rcs_job_partner u_rcs_job_partner (
    .clk_sys, .jobReq, .job, .eeAddr, .cfgAddr, .eeSpd, .eeOn, .updOn, .otpOk, .spi, .jobRsp
  );

  // ----------
  // Helpers
  // ----------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("Checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  function automatic int cnt(input rcs_cmd_e c);
    cnt = 0;
    foreach (jobLog[i]) if (jobLog[i].cmd == c) cnt++;
  endfunction : cnt

  task automatic seq_chk(input rcs_cmd_e e[$]);
    chk("job count", e.size(), jobLog.size());
    foreach (e[i]) chk("job order", e[i], jobLog[i].cmd);
  endtask : seq_chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    // An edge passes so a following call never drives a strobe twice in one step
    @(posedge clk_sys);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge clk_sys);
  endtask : axi_rd

  task automatic cfg(input logic o, e, u, s, input logic [6:0] a, c, input logic [1:0] p);
    otpOk <= o;
    eeOn <= e;
    updOn <= u;
    spi <= s;
    eeAddr <= a;
    cfgAddr <= c;
    eeSpd <= p;
  endtask : cfg

  // Pulse is longer than the synchroniser needs; straps outlive the edge
  task automatic boot(input logic [7:0] s);
    strap_q = s;
    masterResetN <= 1'h0;
    gpioIn <= s;
    repeat (4) @(posedge clk_sys);
    #1 chk("outputs in reset", 0, {clkOutEn, gpioDrive, serialEn, monEn, alarmEn, funcPwrEn});
    @(posedge clk_sys);
    masterResetN <= 1'h1;
    repeat (5) @(posedge clk_sys);
    gpioIn <= ~s;
  endtask : boot

  task automatic wait_run();
    while (alarmEn !== 1'h1) @(posedge clk_sys);
    @(posedge clk_sys);
  endtask : wait_run

  always @(posedge clk_sys) begin
    cyc++;
    if (jobReq && jobRsp.done) jobLog.push_back(job);
    if (jobReq && job.cmd == CMD_DEFAULTS) chk("pins in defaults", 0, {clkOutEn, gpioDrive});
    if (jobReq && job.cmd == CMD_OTP_CFG) chk("config select", strap_q[3:0], job.cfgNum);
    if (jobReq && job.cmd == CMD_OTP_CFG) chk("strap protocol", strap_q[4], serialSpi);
    if (jobReq && job.cmd == CMD_HOTFIX) chk("parallel cal", otpOk, pllCalParallel);
    if (jobReq && job.cmd == CMD_APPLY) chk("ports first", 2'h2, {serialEn, clkOutEn});
    if (alarmEn) chk("enables", 3'h7, {serialEn, clkOutEn, monEn});
    // Last in the process, so nothing runs after the run ends
    if (cyc == 30000) begin
      n_errors++;
      $display("Error timeout expected %0d seen %0d", 0, cyc);
      close_out();
    end
  end

  // ----------
  // Scenarios
  // ----------
  task automatic t_idle();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(REG_STATUS, d, r);
    chk("early read resp", RESP_SLVERR, r);
    chk("early read data", 0, d);
    axi_wr(REG_FUNC_EN, 32'hff, r);
    chk("early write resp", RESP_SLVERR, r);
    $display("test idle done");
  endtask : t_idle

  task automatic t_otp();
    logic [31:0] d;
    logic [1:0] r;
    cfg(1'h1, 1'h0, 1'h0, 1'h0, 7'h00, 7'h00, 2'h0);
    testModeN <= 1'h0;
    boot(8'h15);
    repeat (100) @(posedge clk_sys);
    chk("held by test mode", 0, cnt(CMD_DEFAULTS));
    testModeN <= 1'h1;
    wait_run();
    seq_chk('{CMD_INFO, CMD_PLL_CAL, CMD_DEFAULTS, CMD_OTP_CFG, CMD_HOTFIX, CMD_PLL_CAL,
              CMD_APPLY});
    chk("loaded protocol", 0, serialSpi);
    chk("spi 4-wire", 1, spi4Wire);
    axi_rd(REG_STATUS, d, r);
    chk("status", 32'h5083, d);
    axi_rd(REG_STRAP, d, r);
    chk("straps", 32'h15, d);
    axi_rd(REG_FUNC_EN, d, r);
    chk("power reset", 0, d);
    axi_wr(REG_FUNC_EN, 32'h123456a5, r);
    axi_rd(REG_FUNC_EN, d, r);
    chk("power read", 32'ha5, d);
    chk("power pins", 8'ha5, funcPwrEn);
    axi_wr(REG_STATUS, 32'h0, r);
    axi_rd(REG_STATUS, d, r);
    chk("status kept", 32'h5083, d);
    axi_wr(8'h10, 32'h0, r);
    chk("unmapped write", RESP_DECERR, r);
    axi_rd(8'h0c, d, r);
    chk("unmapped read", RESP_DECERR, r);
    $display("test otp done");
  endtask : t_otp

  task automatic t_ee();
    logic [31:0] d;
    logic [1:0] r;
    rcs_cmd_e e[$];
    jobLog.delete();
    cfg(1'h0, 1'h1, 1'h0, 1'h1, 7'h52, 7'h53, 2'h1);
    boot(8'h23);
    wait_run();
    e = '{CMD_INFO, CMD_PLL_CAL, CMD_DEFAULTS};
    repeat (11) e.push_back(CMD_PROBE);
    repeat (6) e.push_back(CMD_UPDATE);
    e.push_back(CMD_OTP_CFG);
    repeat (8) e.push_back(CMD_EE_CFG);
    e = {e, CMD_HOTFIX, CMD_PLL_CAL, CMD_APPLY};
    seq_chk(e);
    chk("probe", {7'h50, 2'h1}, {jobLog[11].devAddr, jobLog[11].speed});
    chk("block", {7'h53, 16'hf000}, {jobLog[28].devAddr, jobLog[28].offset});
    chk("protocol", 1, serialSpi);
    axi_rd(REG_STATUS, d, r);
    chk("status", 32'h295, d);
    $display("test eeprom done");
  endtask : t_ee

  task automatic t_noee();
    logic [31:0] d;
    logic [1:0] r;
    jobLog.delete();
    cfg(1'h0, 1'h0, 1'h0, 1'h0, 7'h50, 7'h50, 2'h0);
    boot(8'h20);
    wait_run();
    chk("probes", 24, cnt(CMD_PROBE));
    chk("last probe", {7'h57, 2'h2}, {jobLog[26].devAddr, jobLog[26].speed});
    axi_rd(REG_STATUS, d, r);
    chk("status", 32'hcd, d);
    $display("test no eeprom done");
  endtask : t_noee

  task automatic t_upd();
    logic [31:0] d;
    logic [1:0] r;
    jobLog.delete();
    cfg(1'h1, 1'h1, 1'h1, 1'h0, 7'h50, 7'h7f, 2'h0);
    boot(8'h21);
    wait_run();
    chk("restarts", 2, cnt(CMD_INFO));
    chk("updates", 1, cnt(CMD_UPDATE));
    axi_rd(REG_STATUS, d, r);
    chk("update flag", 1, d[ST_UPDATED]);
    $display("test update done");
  endtask : t_upd

  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    rst_n = 1'h0;
    masterResetN = 1'h0;
    testModeN = 1'h1;
    gpioIn = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    cfg(1'h0, 1'h0, 1'h0, 1'h0, 7'h00, 7'h00, 2'h0);
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'h1;
    t_idle();
    t_otp();
    t_ee();
    t_noee();
    t_upd();
    close_out();
  end
endmodule : tb_top
